// ==== logic/tmw_timer.sv ====
// 8-bit timer with waveform output, clock select and APB register access
//
// The APB slave port and the address map were chosen for this implementation.
`default_nettype none

// What this block does
// [R1] nonzero compare mode routes waveform to pin, in PWM modes only 10 and 11; driver only when direction set
// [R2] non-PWM modes: 00 off, 01 toggle, 10 clear, 11 set on match
// [R3] fast PWM: 10 clear on match set at bottom; 11 inverse; else off
// [R4] phase PWM: 10 clear on up match, set on down match; 11 inverse
// [R5] PWM with compare equal TOP and upper bit set: act at TOP instead
// [R6] mode field picks sequence: normal, phase PWM, clear-on-match, fast PWM
// [R7] compare buffered to TOP in PWM; overflow at MAX, or BOTTOM in phase
// [R8] force strobe in non-PWM acts as immediate match on the output
// [R9] force strobe raises no flag and never clears the counter
// [R10] force strobe is write only and reads zero
// [R11] software writes force as zero in PWM modes
// [R12] control B bits 6 to 3 read zero
// [R13] clock select: stop, undivided, or divide by 8,32,64,128,256,1024
// [R14] counter register readable and writable by software
// [R15] counter write blocks the compare match on the next timer clock
// [R16] compare value continuously compared with counter, raising flag and output
// [R17] external clock buffer enabled with async; crystal runs only when bit zero
// [R18] software sets external clock enable before selecting async clocking
// [R19] async select chooses crystal or external clock, else the I/O clock
// [R20] match flag set on match, cleared by vector ack or one written
// [R21] normal wraps FF to 00; clear-on-match returns to zero after match
module tmw_timer
    import tmw_pkg::*;
#(
    parameter int PRESC_W = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port_dir,
    input wire logic port_data,
    output logic compare_output_pin,
    output logic compare_output_pin_oe_n,
    input wire logic crystal_input_pin,
    input wire logic crystal_osc_clk,
    output logic crystal_osc_run,
    output logic ext_clock_buf_en,
    input wire logic compare_vector_ack,
    input wire logic overflow_vector_ack,
    output logic compare_match_flag,
    output logic overflow_flag
);
    initial begin
        if (PRESC_W != 10) begin
            $error("tmw_timer: prescaler must be 10 bits wide");
        end
    end
    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    tmw_ctrl_a_s timer_ctrl_a;
    tmw_async_s async_status;
    logic [2:0] clock_select_field;
    logic [7:0] counter_value, compare_value, compare_active;
    logic count_up, match_block, wave, src_prev;
    logic [PRESC_W-1:0] presc;
    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    logic mapped, wr_en, wr_ctrl_a, wr_ctrl_b, wr_count, wr_compare;
    logic wr_async, wr_flags, force_compare_strobe;
    assign mapped = (paddr == OFS_CTRL_A) || (paddr == OFS_CTRL_B) || (paddr == OFS_COUNT)
        || (paddr == OFS_COMPARE) || (paddr == OFS_ASYNC) || (paddr == OFS_FLAGS);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wr_en = psel & penable & pwrite & mapped;
    assign wr_ctrl_a = wr_en & (paddr == OFS_CTRL_A);
    assign wr_ctrl_b = wr_en & (paddr == OFS_CTRL_B);
    assign wr_count = wr_en & (paddr == OFS_COUNT);
    assign wr_compare = wr_en & (paddr == OFS_COMPARE);
    assign wr_async = wr_en & (paddr == OFS_ASYNC);
    assign wr_flags = wr_en & (paddr == OFS_FLAGS);

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    logic is_pwm, top_case;
    assign is_pwm = (timer_ctrl_a.wgm == WGM_PHASE) || (timer_ctrl_a.wgm == WGM_FAST);
    // only non-PWM modes honour the strobe; PWM writes with a one are harmless
    assign force_compare_strobe = wr_ctrl_b & pwdata[FORCE_BIT] & ~is_pwm; // [R8]
    assign top_case = is_pwm & timer_ctrl_a.com[1] & (compare_active == CNT_MAX); // [R5]

    // ---------------------------------------------------------------
    // clock source and prescaler
    // ---------------------------------------------------------------
    logic src_level, src_tick, tick;
    logic [PRESC_W-1:0] tap_mask;
    // inputs arrive synchronous, so a plain edge compare is enough
    assign src_level = async_status.ext_clock_input_enable ? crystal_input_pin : crystal_osc_clk;
    assign src_tick = async_status.async_sel ? (src_level & ~src_prev) : 1'b1; // [R19]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_prev <= 1'b0;
        end else begin
            src_prev <= src_level;
        end
    end

    // free running: first divided tick lands anywhere within one period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc <= '0;
        end else if (src_tick) begin
            presc <= presc + 1'b1;
        end
    end

    always_comb begin
        unique case (clock_select_field) // [R13]
            3'h2: tap_mask = 10'h007;
            3'h3: tap_mask = 10'h01F;
            3'h4: tap_mask = 10'h03F;
            3'h5: tap_mask = 10'h07F;
            3'h6: tap_mask = 10'h0FF;
            3'h7: tap_mask = 10'h3FF;
            default: tap_mask = 10'h000;
        endcase
    end

    assign tick = (clock_select_field != 3'h0) & src_tick
        & ((presc & tap_mask) == tap_mask); // [R13]

    // ---------------------------------------------------------------
    // counter sequence
    // ---------------------------------------------------------------
    logic [7:0] next_count;
    logic next_up, ovf_event, raw_match, wave_match, at_top, chk_wrote;
    assign raw_match = tick & (counter_value == compare_active) & ~match_block; // [R15] [R16]
    assign wave_match = raw_match & ~top_case; // [R5]
    assign at_top = tick & count_up & (counter_value == CNT_MAX);

    always_comb begin
        next_count = counter_value;
        next_up = count_up;
        ovf_event = 1'b0;
        unique case (timer_ctrl_a.wgm) // [R6]
            WGM_NORMAL, WGM_FAST: begin
                next_count = counter_value + 8'h01; // [R21]
                next_up = 1'b1;
                ovf_event = (counter_value == CNT_MAX); // [R7]
            end
            WGM_CTC: begin
                // top is the compare value; a force never reaches here
                next_count = (counter_value == compare_active) ? CNT_BOTTOM
                    : counter_value + 8'h01; // [R21] [R9]
                next_up = 1'b1;
                ovf_event = (counter_value == CNT_MAX); // [R7]
            end
            WGM_PHASE: begin
                if (count_up) begin
                    if (counter_value == CNT_MAX) begin
                        next_count = CNT_PC_TURN;
                        next_up = 1'b0;
                    end else begin
                        next_count = counter_value + 8'h01;
                    end
                end else if (counter_value == CNT_BOTTOM) begin
                    next_count = CNT_PC_RISE;
                    next_up = 1'b1;
                    ovf_event = 1'b1; // [R7]
                end else begin
                    next_count = counter_value - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_value <= RST_REG;
            count_up <= 1'b1;
        end else if (wr_count) begin
            counter_value <= pwdata[7:0]; // [R14]
        end else if (tick) begin
            counter_value <= next_count;
            count_up <= next_up;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            match_block <= 1'b0;
        end else if (wr_count) begin
            match_block <= 1'b1; // [R15]
        end else if (tick) begin
            match_block <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_ctrl_a <= tmw_ctrl_a_s'(4'h0);
            clock_select_field <= 3'h0;
            async_status <= tmw_async_s'(2'h0);
        end else begin
            if (wr_ctrl_a) begin
                timer_ctrl_a.com <= tmw_com_e'(pwdata[COM_LSB+1:COM_LSB]);
                timer_ctrl_a.wgm <= tmw_wgm_e'(pwdata[WGM_LSB+1:WGM_LSB]);
            end
            if (wr_ctrl_b) begin
                clock_select_field <= pwdata[CS_LSB+2:CS_LSB];
            end
            if (wr_async) begin
                async_status.ext_clock_input_enable <= pwdata[EXT_CLOCK_INPUT_ENABLE_BIT];
                async_status.async_sel <= pwdata[ASYNC_BIT];
            end
        end
    end

    // buffered compare: PWM waits for TOP so a period never glitches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_value <= RST_REG;
            compare_active <= RST_REG;
        end else begin
            if (wr_compare) begin
                compare_value <= pwdata[7:0];
            end
            if (!is_pwm || at_top) begin
                compare_active <= compare_value; // [R7]
            end
        end
    end

    // ---------------------------------------------------------------
    // waveform output
    // ---------------------------------------------------------------
    logic next_wave, pin_override;
    always_comb begin
        next_wave = wave;
        unique case (timer_ctrl_a.wgm)
            WGM_NORMAL, WGM_CTC: begin
                if (wave_match || force_compare_strobe) begin // [R2] [R8]
                    unique case (timer_ctrl_a.com)
                        COM_OFF: next_wave = wave;
                        COM_TOGGLE: next_wave = ~wave;
                        COM_CLEAR: next_wave = 1'b0;
                        COM_SET: next_wave = 1'b1;
                    endcase
                end
            end
            WGM_FAST: begin
                if (wave_match && timer_ctrl_a.com[1]) begin
                    next_wave = timer_ctrl_a.com[0]; // [R3]
                end
                if (at_top && timer_ctrl_a.com[1]) begin
                    next_wave = ~timer_ctrl_a.com[0]; // [R3] [R5]
                end
            end
            WGM_PHASE: begin
                if (wave_match && timer_ctrl_a.com[1]) begin
                    next_wave = count_up ? timer_ctrl_a.com[0] : ~timer_ctrl_a.com[0]; // [R4]
                end
                if (at_top && top_case) begin
                    next_wave = ~timer_ctrl_a.com[0]; // [R5]
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wave <= 1'b0;
        end else begin
            wave <= next_wave;
        end
    end

    assign pin_override = is_pwm ? timer_ctrl_a.com[1] : (timer_ctrl_a.com != COM_OFF); // [R1]
    assign compare_output_pin = pin_override ? wave : port_data; // [R1]
    assign compare_output_pin_oe_n = ~port_dir; // [R1]

    // ---------------------------------------------------------------
    // clock source pins
    // ---------------------------------------------------------------
    assign ext_clock_buf_en = async_status.ext_clock_input_enable & async_status.async_sel; // [R17]
    assign crystal_osc_run = ~async_status.ext_clock_input_enable; // [R17]

    // ---------------------------------------------------------------
    // status flags, set wins over clear
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_match_flag <= 1'b0;
        end else if (raw_match) begin
            compare_match_flag <= 1'b1; // [R20] [R9]
        end else if (compare_vector_ack || (wr_flags && pwdata[CMPF_BIT])) begin
            compare_match_flag <= 1'b0; // [R20]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag <= 1'b0;
        end else if (tick && ovf_event && !wr_count) begin
            overflow_flag <= 1'b1;
        end else if (overflow_vector_ack || (wr_flags && pwdata[OVF_BIT])) begin
            overflow_flag <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // read data, captured in the setup cycle
    // ---------------------------------------------------------------
    logic [7:0] rd_byte;
    always_comb begin
        unique case (paddr)
            OFS_CTRL_A: rd_byte = {timer_ctrl_a.com, 4'h0, timer_ctrl_a.wgm};
            OFS_CTRL_B: rd_byte = {5'h00, clock_select_field}; // [R10] [R12]
            OFS_COUNT: rd_byte = counter_value; // [R14]
            OFS_COMPARE: rd_byte = compare_value;
            OFS_ASYNC: rd_byte = {1'b0, async_status.ext_clock_input_enable, async_status.async_sel, 5'h00};
            OFS_FLAGS: rd_byte = {6'h00, compare_match_flag, overflow_flag};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // helper: a counter write stays pending until the next timer clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_wrote <= 1'b0;
        end else if (wr_count || tick) begin
            chk_wrote <= wr_count;
        end
    end
    a_ctrlb_reads_zero: assert property ( // [R10]
        psel && !penable && !pwrite && paddr == OFS_CTRL_B |=> prdata[7:3] == 5'h00)
        else $error("control B upper bits read nonzero");
    a_force_no_flag: assert property ( // [R9]
        force_compare_strobe && !raw_match && !compare_match_flag |=> !compare_match_flag)
        else $error("force strobe raised the match flag");
    a_write_blocks_match: assert property ( // [R15]
        chk_wrote && tick |-> !raw_match)
        else $error("match not blocked after counter write");
    a_normal_wraps: assert property ( // [R21]
        tick && !wr_count && timer_ctrl_a.wgm == WGM_NORMAL && counter_value == CNT_MAX
        |=> counter_value == CNT_BOTTOM && overflow_flag)
        else $error("normal mode did not wrap with overflow");
    a_phase_bottom_ovf: assert property ( // [R7]
        tick && !wr_count && timer_ctrl_a.wgm == WGM_PHASE && !count_up
        && counter_value == CNT_BOTTOM |=> overflow_flag && count_up)
        else $error("phase mode bottom missed overflow");
    a_match_sets_flag: assert property ( // [R20]
        raw_match |=> compare_match_flag)
        else $error("match did not set the flag");
    a_ctc_clears: assert property ( // [R21]
        tick && !wr_count && timer_ctrl_a.wgm == WGM_CTC && counter_value == compare_active
        |=> counter_value == CNT_BOTTOM)
        else $error("clear-on-match did not restart");
    a_fast_bottom_set: assert property ( // [R3]
        at_top && !wr_ctrl_a && timer_ctrl_a.wgm == WGM_FAST && timer_ctrl_a.com == COM_CLEAR
        |=> wave)
        else $error("fast PWM output not set at bottom");
    a_nonpwm_toggle: assert property ( // [R2]
        (wave_match || force_compare_strobe) && !is_pwm && timer_ctrl_a.com == COM_TOGGLE
        |=> wave != $past(wave))
        else $error("toggle mode did not toggle");
    a_pin_routing: assert property ( // [R1]
        (timer_ctrl_a.com[1] || (timer_ctrl_a.com[0] && !is_pwm)) |-> compare_output_pin == wave)
        else $error("waveform not routed to pin");
    a_stop_no_tick: assert property ( // [R13]
        clock_select_field == 3'h0 |-> !tick)
        else $error("stopped timer ticked");
    c_ovf_normal: cover property (tick && ovf_event && timer_ctrl_a.wgm == WGM_NORMAL);
    c_phase_turn: cover property (at_top && timer_ctrl_a.wgm == WGM_PHASE);
    c_force: cover property (force_compare_strobe && timer_ctrl_a.com != COM_OFF);
    c_top_case: cover property (at_top && top_case);
endmodule
`default_nettype wire

// ==== shared/tmw_pkg.sv ====
// shared constants and types for the 8-bit timer waveform control block
`default_nettype none
package tmw_pkg;
    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_COMPARE = 8'h0C;
    localparam logic [7:0] OFS_ASYNC = 8'h10;
    localparam logic [7:0] OFS_FLAGS = 8'h14;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int COM_LSB = 6;
    localparam int WGM_LSB = 0;
    localparam int FORCE_BIT = 7;
    localparam int CS_LSB = 0;
    localparam int EXT_CLOCK_INPUT_ENABLE_BIT = 6;
    localparam int ASYNC_BIT = 5;
    localparam int CMPF_BIT = 1;
    localparam int OVF_BIT = 0;
    // ---------------------------------------------------------------
    // reset values and counter limits
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_PC_TURN = 8'hFE;
    localparam logic [7:0] CNT_PC_RISE = 8'h01;
    // ---------------------------------------------------------------
    // modes and carriers
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        WGM_NORMAL = 2'b00,
        WGM_PHASE = 2'b01,
        WGM_CTC = 2'b10,
        WGM_FAST = 2'b11
    } tmw_wgm_e;
    typedef enum logic [1:0] {
        COM_OFF = 2'b00,
        COM_TOGGLE = 2'b01,
        COM_CLEAR = 2'b10,
        COM_SET = 2'b11
    } tmw_com_e;
    typedef struct packed {
        tmw_com_e com;
        tmw_wgm_e wgm;
    } tmw_ctrl_a_s;
    typedef struct packed {
        logic ext_clock_input_enable;
        logic async_sel;
    } tmw_async_s;
endpackage
`default_nettype wire

// ==== dv/tb_tmw_timer.sv ====
// self-checking bench for the 8-bit timer waveform block
`default_nettype none
module tb_tmw_timer
    import tmw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, psel, penable, pwrite, port_dir, port_data, xin, xosc, cack, oack;
    logic look, pready, pslverr, pin, pin_oe_n, osc_run, buf_en, cflag, oflag;
    logic [7:0] paddr, v;
    logic [31:0] pwdata, prdata;
    logic [31:0] q_exp[$];
    int q_tol[$];
    logic [3:0] q_out[$];
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    int seed = 33;
    int h;
    int dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    tmw_com_e coms[5] = '{COM_TOGGLE, COM_CLEAR, COM_SET, COM_TOGGLE, COM_TOGGLE};
    logic [7:0] dt_cfg[6] = '{8'h83, 8'hC3, 8'h81, 8'hC1, 8'h83, 8'h43};
    logic [7:0] dt_cmp[6] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'hFF, 8'h80};
    int dt_hi[6] = '{129, 127, 128, 382, 256, 0};

    tmw_timer u_tmw_timer (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_dir(port_dir), .port_data(port_data),
        .compare_output_pin(pin), .compare_output_pin_oe_n(pin_oe_n),
        .crystal_input_pin(xin), .crystal_osc_clk(xosc), .crystal_osc_run(osc_run),
        .ext_clock_buf_en(buf_en), .compare_vector_ack(cack), .overflow_vector_ack(oack),
        .compare_match_flag(cflag), .overflow_flag(oflag)
    );

    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic near(input logic [31:0] got, input logic [31:0] exp, input int tol);
        logic ok;
        ok = (got + tol >= exp) && (got <= exp + tol);
        n_compared++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // extra idle edge at the end so no strobe is driven twice in one step
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input int tol);
        q_exp.push_back(e);
        q_tol.push_back(tol);
        apb(a, 0, 32'h0);
    endtask

    task automatic exp_out(input logic [3:0] e);
        q_out.push_back(e);
        look <= 1;
        @(posedge clk);
        look <= 0;
        @(posedge clk);
    endtask

    task automatic close_out;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // watcher and hang limit
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            near({31'h0, pslverr}, {31'h0, paddr > OFS_FLAGS}, 0);
            if (!pwrite) near(prdata, q_exp.pop_front(), q_tol.pop_front());
        end
        if (look) near({28'h0, buf_en, osc_run, pin_oe_n, pin},
            {28'h0, q_out.pop_front()}, 0);
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            close_out;
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, port_data, xin, xosc, cack, oack, look} = '0;
        port_dir = 1;
        paddr = 8'h00;
        pwdata = 32'h0;
        rst_n = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        for (int a = 0; a <= 24; a += 4) rd(8'(a), 32'h0, 0);
        exp_out(4'h4);
        wr(OFS_CTRL_B, 32'hF8);
        rd(OFS_CTRL_B, 32'h0, 0);
        wr(OFS_CTRL_B, 32'h7B);
        rd(OFS_CTRL_B, 32'h3, 0);
        wr(OFS_CTRL_B, 32'h0);
        repeat (4) begin
            v = 8'($random(seed));
            wr(OFS_COUNT, {24'($random(seed)), v});
            rd(OFS_COUNT, {24'h0, v}, 0);
            wr(OFS_COMPARE, {24'h0, ~v});
            rd(OFS_COMPARE, {24'h0, ~v}, 0);
        end
        $display("register test done");
        h = 0;
        for (int i = 0; i < 5; i++) begin
            wr(OFS_CTRL_A, {24'h0, coms[i], 4'h0, i > 2 ? WGM_CTC : WGM_NORMAL});
            wr(OFS_CTRL_B, 32'h80);
            h = coms[i] == COM_TOGGLE ? 32'(h == 0) : 32'(coms[i] == COM_SET);
            exp_out({3'b010, h[0]});
        end
        rd(OFS_FLAGS, 32'h0, 0);
        rd(OFS_COUNT, {24'h0, v}, 0);
        wr(OFS_CTRL_A, 32'h0);
        repeat (4) begin
            {port_dir, port_data} <= 2'($random(seed));
            @(posedge clk);
            exp_out({2'b01, ~port_dir, port_data});
        end
        port_dir <= 1;
        port_data <= 0;
        $display("force test done");
        wr(OFS_COMPARE, 32'h05);
        wr(OFS_COUNT, 32'h05);
        wr(OFS_CTRL_B, 32'h1);
        repeat (60) @(posedge clk);
        rd(OFS_FLAGS, 32'h0, 0);
        wr(OFS_CTRL_B, 32'h0);
        wr(OFS_COMPARE, 32'h80);
        wr(OFS_COUNT, 32'hFC);
        wr(OFS_CTRL_B, 32'h1);
        for (h = 0; h < 20 && oflag !== 1'b1; h++) @(posedge clk);
        rd(OFS_FLAGS, 32'h1, 0);
        near({30'h0, cflag, oflag}, 32'h1, 0);
        wr(OFS_FLAGS, 32'h1);
        rd(OFS_FLAGS, 32'h0, 0);
        for (h = 0; h < 300 && oflag !== 1'b1; h++) @(posedge clk);
        oack <= 1;
        @(posedge clk);
        oack <= 0;
        @(posedge clk);
        rd(OFS_FLAGS, 32'h2, 0);
        near({30'h0, cflag, oflag}, 32'h2, 0);
        cack <= 1;
        @(posedge clk);
        cack <= 0;
        @(posedge clk);
        rd(OFS_FLAGS, 32'h0, 0);
        $display("flag test done");
        wr(OFS_CTRL_B, 32'h0);
        wr(OFS_COUNT, 32'h0);
        wr(OFS_COMPARE, 32'h10);
        wr(OFS_CTRL_A, 32'h42);
        wr(OFS_CTRL_B, 32'h1);
        repeat (20) @(posedge clk);
        h = 0;
        // sample the pin mid-cycle, where it is settled
        @(negedge clk);
        v[0] = pin;
        repeat (170) begin
            @(negedge clk);
            h += int'(pin != v[0]);
            v[0] = pin;
        end
        @(posedge clk);
        near(32'(h), 32'd10, 1);
        repeat (3) rd(OFS_COUNT, 32'h8, 8);
        $display("clear-on-match test done");
        for (int i = 0; i < 6; i++) begin
            wr(OFS_CTRL_B, 32'h0);
            wr(OFS_COMPARE, {24'h0, dt_cmp[i]});
            wr(OFS_CTRL_A, {24'h0, dt_cfg[i]});
            wr(OFS_CTRL_B, 32'h1);
            repeat (520) @(posedge clk);
            h = 0;
            repeat (dt_cfg[i][1] ? 256 : 510) begin
                @(negedge clk);
                h += int'(pin);
            end
            @(posedge clk);
            near(32'(h), 32'(dt_hi[i]), 3);
        end
        $display("pwm test done");
        // prescaler runs free, yet a window of eight periods holds exactly eight ticks; the check allows one more or less
        wr(OFS_CTRL_A, 32'h0);
        for (int cs = 0; cs < 8; cs++) begin
            wr(OFS_CTRL_B, 32'h0);
            wr(OFS_COUNT, 32'h0);
            wr(OFS_CTRL_B, 32'(cs));
            repeat (cs > 0 ? 8 * dv[cs] - 3 : 20) @(posedge clk);
            wr(OFS_CTRL_B, 32'h0);
            rd(OFS_COUNT, cs > 0 ? 32'h8 : 32'h0, cs > 0 ? 1 : 0);
        end
        $display("prescaler test done");
        for (int e = 1; e >= 0; e--) begin
            // clock enable bit goes in first, async select only after it
            wr(OFS_ASYNC, e > 0 ? 32'h40 : 32'h00);
            wr(OFS_ASYNC, e > 0 ? 32'h60 : 32'h20);
            rd(OFS_ASYNC, e > 0 ? 32'h60 : 32'h20, 0);
            exp_out(e > 0 ? 4'h8 : 4'h4);
            wr(OFS_COUNT, 32'h0);
            wr(OFS_CTRL_B, 32'h1);
            for (int i = 0; i < 20; i++) begin
                xin <= e > 0 ? i[1] : i[0];
                xosc <= e > 0 ? i[0] : i[1];
                repeat (2) @(posedge clk);
            end
            xin <= 0;
            xosc <= 0;
            repeat (4) @(posedge clk);
            wr(OFS_CTRL_B, 32'h0);
            rd(OFS_COUNT, 32'h5, 0);
        end
        $display("async clock test done");
        close_out;
    end
endmodule
`default_nettype wire
